// ### src/event_log_mission_control.v
// Event-logging mission controller: edge selection, mission start/stop, log write and indirect read port.
// Operation
// - Falling, rising or both edges count as events per the two trigger select bits.
// - Trigger select 00 ignores the event pin and refuses any mission start.
// - Host writes pointer low at 41h, high at 42h, reads log byte at 43h.
// - Log holds 2048 bytes at addresses 0000h to 07FFh.
// - Each duration takes two bytes, low first; address advances per byte.
// - Host start sets arm, stamps time, zeros event-0 bytes, counts, starts ticking.
// - Host start is ignored unless the log cleared flag is set.
// - Arming is accepted only with the cleared flag set; waits for first event.
// - First event while armed starts mission, stamps, zeros event-0, counts, ticks.
// - Each later event writes the elapsed tick count into the next log bytes.
// - A tick is one second, minute or hour as the interval select says.
// - Host write of 0 to running ends mission after any recording finishes.
// - Running and arm read 1 until the mission has really ended.
// - A stopped mission cannot restart until the log is cleared again.
// - With wrap enabled, overrun restarts at the start stamp like a new mission.
// - Wrap writes fresh stamp, elapsed since event 1024 into event-0, next at 0000h.
// - Wrap sets the log wrapped flag.
// - Without wrap, recording stops once the write pointer passes 07FFh to 0000h.
// - After a full log without wrap, events are still counted.
// - The host has no write path into log memory.
// - During a mission reads above 2Fh return 00h.
// - Only the low 11 bits of the written pointer are used.
// - No mission starts while both interval select bits are zero.
// - Any host write during a mission ends it after current recording completes.
`timescale 1ns/1ps
`include "evlog_defines.vh"
module event_log_mission_control (
	input  wire        I_REF_CLK,
	input  wire        I_RESET_N,
	input  wire        I_EVENT,
	input  wire [63:0] I_RTC_TIME,
	input  wire        I_SEC_TICK,
	input  wire        I_MIN_TICK,
	input  wire        I_HOUR_TICK,
	input  wire        I_CLEAR_DONE,
	input  wire        I_WR,
	input  wire        I_RD,
	input  wire [7:0]  I_ADDR,
	input  wire [7:0]  I_WDATA,
	output reg  [7:0]  O_RDATA,
	output wire        O_MISSION_RUNNING,
	output wire        O_MISSION_ARM
);
	// ****************************************************
	// States
	// ****************************************************
	localparam [4:0] ST_IDLE  = 5'h01;
	localparam [4:0] ST_ARMED = 5'h02;
	localparam [4:0] ST_RUN   = 5'h04;
	localparam [4:0] ST_LOGLO = 5'h08;
	localparam [4:0] ST_LOGHI = 5'h10;

	reg [4:0]                 state;
	reg [7:0]                 control;
	reg                       log_cleared_flag;
	reg                       log_wrapped_flag;
	reg                       log_full;
	reg                       stop_pending;
	reg [63:0]                start_stamp;
	reg [15:0]                event0_elapsed;
	reg [23:0]                event_count;
	reg [15:0]                elapsed_tick_counter;
	reg [15:0]                logged_value;
	reg [`EVLOG_LOG_AW-1:0]   write_ptr;
	reg [`EVLOG_LOG_AW-1:0]   read_ptr;
	reg [7:0]                 log_mem [0:`EVLOG_LOG_BYTES-1];
	reg [7:0]                 next_rdata;
	reg                       tick;
	wire                      ev_rise;
	wire                      ev_fall;
	wire                      event_hit;
	wire                      trig_valid;
	wire                      dis_valid;
	wire                      in_mission;
	wire                      busy_logging;
	wire                      start_ok;
	wire                      arm_cfg_ok;
	wire                      host_start;
	wire                      host_arm;
	wire [7:0]                status;

	// ****************************************************
	// Event detection
	// ****************************************************
	evlog_edge_detect u_edge (
		.i_clk     (I_REF_CLK),
		.i_reset_n (I_RESET_N),
		.i_pin     (I_EVENT),
		.o_rise    (ev_rise),
		.o_fall    (ev_fall)
	);

	assign event_hit = (control[`EVLOG_CTL_TR0] & ev_fall) | (control[`EVLOG_CTL_TR1] & ev_rise);
	assign trig_valid = control[`EVLOG_CTL_TR0] | control[`EVLOG_CTL_TR1];
	assign dis_valid  = control[`EVLOG_CTL_DIS_HI] | control[`EVLOG_CTL_DIS_LO];
	assign busy_logging = (state == ST_LOGLO) | (state == ST_LOGHI);
	assign in_mission   = (state == ST_RUN) | busy_logging;

	// ****************************************************
	// Start qualification
	// ****************************************************
	// The cleared flag drops at every start, so a stopped mission stays dead until a new clear.
	assign start_ok   = log_cleared_flag & trig_valid & dis_valid;
	assign host_start = I_WR & (I_ADDR == `EVLOG_ADDR_STATUS) & I_WDATA[`EVLOG_STS_RUNNING]
		& ((state == ST_IDLE) | (state == ST_ARMED)) & start_ok;
	// An arm request is judged on the byte being written, so one control write may set the
	// trigger and interval fields and arm the mission together.
	assign arm_cfg_ok = log_cleared_flag & (I_WDATA[`EVLOG_CTL_TR0] | I_WDATA[`EVLOG_CTL_TR1])
		& (I_WDATA[`EVLOG_CTL_DIS_HI] | I_WDATA[`EVLOG_CTL_DIS_LO]);
	assign host_arm   = I_WR & (I_ADDR == `EVLOG_ADDR_CONTROL) & I_WDATA[`EVLOG_CTL_ARM]
		& (state == ST_IDLE) & arm_cfg_ok;

	assign O_MISSION_RUNNING = in_mission;
	assign O_MISSION_ARM     = in_mission | (state == ST_ARMED);
	assign status = {1'b0, log_cleared_flag, in_mission, 2'h0, log_wrapped_flag, 2'h0};

	// ****************************************************
	// Tick selection
	// ****************************************************
	always @* begin
		case (control[`EVLOG_CTL_DIS_HI:`EVLOG_CTL_DIS_LO])
		`EVLOG_DIS_SEC:  tick = I_SEC_TICK;
		`EVLOG_DIS_MIN:  tick = I_MIN_TICK;
		`EVLOG_DIS_HOUR: tick = I_HOUR_TICK;
		default:         tick = 1'b0;
		endcase
	end

	// ****************************************************
	// Log memory write port (no host path exists)
	// ****************************************************
	always @(posedge I_REF_CLK) begin
		if (state == ST_LOGLO) begin
			log_mem[write_ptr] <= logged_value[7:0];
		end else if (state == ST_LOGHI) begin
			log_mem[write_ptr] <= logged_value[15:8];
		end
	end

	// ****************************************************
	// Mission control
	// ****************************************************
	always @(posedge I_REF_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			state                <= ST_IDLE;
			control              <= `EVLOG_CTL_RESET;
			log_cleared_flag     <= 1'b0;
			log_wrapped_flag     <= 1'b0;
			log_full             <= 1'b0;
			stop_pending         <= 1'b0;
			start_stamp          <= 64'h0;
			event0_elapsed       <= 16'h0;
			event_count          <= 24'h0;
			elapsed_tick_counter <= 16'h0;
			logged_value         <= 16'h0;
			write_ptr            <= {`EVLOG_LOG_AW{1'b0}};
		end else begin
			if (I_CLEAR_DONE && !in_mission) begin
				log_cleared_flag     <= 1'b1;
				log_wrapped_flag     <= 1'b0;
				log_full             <= 1'b0;
				start_stamp          <= 64'h0;
				event0_elapsed       <= 16'h0;
				event_count          <= 24'h0;
				elapsed_tick_counter <= 16'h0;
				write_ptr            <= {`EVLOG_LOG_AW{1'b0}};
			end
			// Any write during a mission is a stop request, held until logging is idle.
			if (in_mission && I_WR) begin
				stop_pending <= 1'b1;
			end
			if (in_mission && tick) begin
				elapsed_tick_counter <= elapsed_tick_counter + 16'h1;
			end
			case (state)
			ST_IDLE: begin
				// A refused arm still stores the other control fields, with the arm bit held low.
				if (I_WR && I_ADDR == `EVLOG_ADDR_CONTROL) begin
					control <= I_WDATA & ~(arm_cfg_ok ? 8'h00 : 8'h80);
				end
				if (host_start) begin
					control[`EVLOG_CTL_ARM] <= 1'b1;
				end
				if (host_start) begin
					state                <= ST_RUN;
					log_cleared_flag     <= 1'b0;
					start_stamp          <= I_RTC_TIME;
					event0_elapsed       <= 16'h0;
					event_count          <= event_count + 24'h1;
					elapsed_tick_counter <= 16'h0;
					stop_pending         <= 1'b0;
				end else if (host_arm) begin
					state <= ST_ARMED;
				end
			end
			ST_ARMED: begin
				if (host_start || (event_hit && trig_valid && dis_valid)) begin
					state                   <= ST_RUN;
					control[`EVLOG_CTL_ARM] <= 1'b1;
					log_cleared_flag        <= 1'b0;
					start_stamp             <= I_RTC_TIME;
					event0_elapsed          <= 16'h0;
					event_count             <= event_count + 24'h1;
					elapsed_tick_counter    <= 16'h0;
					stop_pending            <= 1'b0;
				end else if (I_WR && I_ADDR == `EVLOG_ADDR_CONTROL && !I_WDATA[`EVLOG_CTL_ARM]) begin
					control <= I_WDATA;
					state   <= ST_IDLE;
				end
			end
			ST_RUN: begin
				if (event_hit) begin
					event_count          <= event_count + 24'h1;
					elapsed_tick_counter <= 16'h0;
					if (!log_full) begin
						logged_value <= elapsed_tick_counter;
						state        <= ST_LOGLO;
					end else if (control[`EVLOG_CTL_WRAP]) begin
						start_stamp      <= I_RTC_TIME;
						event0_elapsed   <= elapsed_tick_counter;
						log_full         <= 1'b0;
						log_wrapped_flag <= 1'b1;
					end
				end else if (stop_pending || (I_WR && in_mission)) begin
					state                   <= ST_IDLE;
					control[`EVLOG_CTL_ARM] <= 1'b0;
					stop_pending            <= 1'b0;
				end
			end
			ST_LOGLO: begin
				write_ptr <= write_ptr + {{(`EVLOG_LOG_AW-1){1'b0}}, 1'b1};
				state     <= ST_LOGHI;
			end
			ST_LOGHI: begin
				write_ptr <= write_ptr + {{(`EVLOG_LOG_AW-1){1'b0}}, 1'b1};
				// Filling the last byte rolls the pointer to zero; without wrap, later events are then only counted.
				if (write_ptr == `EVLOG_LOG_LAST) begin
					log_full <= 1'b1;
				end
				state <= ST_RUN;
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end

	// ****************************************************
	// Indirect read pointer
	// ****************************************************
	always @(posedge I_REF_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			read_ptr <= {`EVLOG_LOG_AW{1'b0}};
		end else if (I_WR && !in_mission && I_ADDR == `EVLOG_ADDR_PTR_LO) begin
			read_ptr[7:0] <= I_WDATA;
		end else if (I_WR && !in_mission && I_ADDR == `EVLOG_ADDR_PTR_HI) begin
			read_ptr[`EVLOG_LOG_AW-1:8] <= I_WDATA[`EVLOG_LOG_AW-9:0];
		end else if (I_RD && !in_mission && I_ADDR == `EVLOG_ADDR_DATA && read_ptr != `EVLOG_LOG_LAST) begin
			// Streaming reads advance the pointer and park at the last byte.
			read_ptr <= read_ptr + {{(`EVLOG_LOG_AW-1){1'b0}}, 1'b1};
		end
	end

	// ****************************************************
	// Read data mux
	// ****************************************************
	always @* begin
		next_rdata = 8'h00;
		if (in_mission && I_ADDR > `EVLOG_ADDR_USER_LAST) begin
			next_rdata = 8'h00;
		end else if (I_ADDR >= `EVLOG_ADDR_STAMP0 && I_ADDR < `EVLOG_ADDR_EV0_LO) begin
			next_rdata = start_stamp[{I_ADDR[2:0], 3'h0} +: 8];
		end else begin
			case (I_ADDR)
			`EVLOG_ADDR_CONTROL:   next_rdata = {O_MISSION_ARM, control[6:0]};
			`EVLOG_ADDR_STATUS:    next_rdata = status;
			`EVLOG_ADDR_EV0_LO:    next_rdata = event0_elapsed[7:0];
			`EVLOG_ADDR_EV0_HI:    next_rdata = event0_elapsed[15:8];
			`EVLOG_ADDR_COUNT_LO:  next_rdata = event_count[7:0];
			`EVLOG_ADDR_COUNT_MID: next_rdata = event_count[15:8];
			`EVLOG_ADDR_COUNT_HI:  next_rdata = event_count[23:16];
			`EVLOG_ADDR_ETC_LO:    next_rdata = elapsed_tick_counter[7:0];
			`EVLOG_ADDR_ETC_HI:    next_rdata = elapsed_tick_counter[15:8];
			`EVLOG_ADDR_WPTR_LO:   next_rdata = write_ptr[7:0];
			`EVLOG_ADDR_WPTR_HI:   next_rdata = {5'h0, write_ptr[`EVLOG_LOG_AW-1:8]};
			`EVLOG_ADDR_PTR_LO:    next_rdata = read_ptr[7:0];
			`EVLOG_ADDR_PTR_HI:    next_rdata = {5'h0, read_ptr[`EVLOG_LOG_AW-1:8]};
			`EVLOG_ADDR_DATA:      next_rdata = log_mem[read_ptr];
			default:               next_rdata = 8'h00;
			endcase
		end
	end

	always @(posedge I_REF_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			O_RDATA <= 8'h00;
		end else if (I_RD) begin
			O_RDATA <= next_rdata;
		end
	end
endmodule

// ### src/evlog_defines.vh
// Register offsets, field positions, reset values and sizes of the event-log mission controller.
`ifndef EVLOG_DEFINES_VH
`define EVLOG_DEFINES_VH

// ****************************************************
// Register offsets
// ****************************************************
`define EVLOG_ADDR_CONTROL    8'h0e
`define EVLOG_ADDR_STATUS     8'h0f
`define EVLOG_ADDR_USER_LAST  8'h2f
`define EVLOG_ADDR_STAMP0     8'h30
`define EVLOG_ADDR_EV0_LO     8'h38
`define EVLOG_ADDR_EV0_HI     8'h39
`define EVLOG_ADDR_COUNT_LO   8'h3a
`define EVLOG_ADDR_COUNT_MID  8'h3b
`define EVLOG_ADDR_COUNT_HI   8'h3c
`define EVLOG_ADDR_ETC_LO     8'h3d
`define EVLOG_ADDR_ETC_HI     8'h3e
`define EVLOG_ADDR_WPTR_LO    8'h3f
`define EVLOG_ADDR_WPTR_HI    8'h40
`define EVLOG_ADDR_PTR_LO     8'h41
`define EVLOG_ADDR_PTR_HI     8'h42
`define EVLOG_ADDR_DATA       8'h43

// ****************************************************
// Control register fields
// ****************************************************
`define EVLOG_CTL_ARM         7
`define EVLOG_CTL_CLR         6
`define EVLOG_CTL_DIS_HI      5
`define EVLOG_CTL_DIS_LO      4
`define EVLOG_CTL_WRAP        3
`define EVLOG_CTL_TR1         2
`define EVLOG_CTL_TR0         1
`define EVLOG_CTL_COE         0
`define EVLOG_CTL_RESET       8'h00

// ****************************************************
// Status register fields
// ****************************************************
`define EVLOG_STS_CLEARED     6
`define EVLOG_STS_RUNNING     5
`define EVLOG_STS_WRAPPED     2

// ****************************************************
// Tick interval codes and log size
// ****************************************************
`define EVLOG_DIS_SEC         2'h1
`define EVLOG_DIS_MIN         2'h2
`define EVLOG_DIS_HOUR        2'h3
`define EVLOG_LOG_BYTES       2048
`define EVLOG_LOG_AW          11
`define EVLOG_LOG_LAST        11'h7ff

`endif

// ### src/evlog_edge_detect.v
// Synchroniser and edge detector for the external event input.
`timescale 1ns/1ps
module evlog_edge_detect (
	input  wire i_clk,
	input  wire i_reset_n,
	input  wire i_pin,
	output wire o_rise,
	output wire o_fall
);
	reg sync_a;
	reg sync_b;
	reg prev;

	// The first stage is read only by the second stage to keep metastability contained.
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			prev   <= 1'b0;
		end else begin
			sync_a <= i_pin;
			sync_b <= sync_a;
			prev   <= sync_b;
		end
	end

	assign o_rise = sync_b & ~prev;
	assign o_fall = ~sync_b & prev;
endmodule

// ### dv/evlog_mission_props.sv
// Port-level assertion checker for the event-log mission controller.
`timescale 1ns/1ps
module evlog_mission_props (
	input wire logic       I_REF_CLK,
	input wire logic       I_RESET_N,
	input wire logic       I_CLEAR_DONE,
	input wire logic       I_WR,
	input wire logic       I_RD,
	input wire logic [7:0] I_ADDR,
	input wire logic [7:0] I_WDATA,
	input wire logic [7:0] O_RDATA,
	input wire logic       O_MISSION_RUNNING,
	input wire logic       O_MISSION_ARM
);
	logic       cleared;
	logic [7:0] ctl;
	logic       cfg_ok;
	// ********
	// Shadow of the cleared flag and control byte
	// ********
	// Control writes in a mission are refused, so the shadow only follows idle writes.
	always @(posedge I_REF_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			cleared <= 1'b0;
			ctl     <= 8'h00;
		end else begin
			if (O_MISSION_RUNNING)
				cleared <= 1'b0;
			else if (I_CLEAR_DONE)
				cleared <= 1'b1;
			if (I_WR && I_ADDR == 8'h0e && !O_MISSION_RUNNING)
				ctl <= I_WDATA;
		end
	end
	assign cfg_ok = (ctl[2:1] != 2'h0) && (ctl[5:4] != 2'h0);
	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RESET_N);
	sequence s_stop;
		##[1:4] (!O_MISSION_RUNNING && !O_MISSION_ARM);
	endsequence
	property p_arm_with_run;
		O_MISSION_RUNNING |-> O_MISSION_ARM;
	endproperty
	a_arm_with_run: assert property (p_arm_with_run) else $error("running without arm");
	property p_stop_on_write;
		O_MISSION_RUNNING && I_WR |-> s_stop;
	endproperty
	a_stop_on_write: assert property (p_stop_on_write) else $error("mission not ended");
	property p_arm_needs_clear;
		$rose(O_MISSION_ARM) |-> $past(cleared);
	endproperty
	a_arm_needs_clear: assert property (p_arm_needs_clear) else $error("armed uncleared");
	property p_run_needs_clear;
		$rose(O_MISSION_RUNNING) |-> $past(cleared);
	endproperty
	a_run_needs_clear: assert property (p_run_needs_clear) else $error("started uncleared");
	property p_run_needs_cfg;
		$rose(O_MISSION_RUNNING) |-> $past(cfg_ok);
	endproperty
	a_run_needs_cfg: assert property (p_run_needs_cfg) else $error("started with bad config");
	property p_host_start;
		I_WR && I_ADDR == 8'h0f && I_WDATA[5] && !O_MISSION_RUNNING && cleared && cfg_ok
			|=> O_MISSION_RUNNING && O_MISSION_ARM;
	endproperty
	a_host_start: assert property (p_host_start) else $error("host start missed");
	property p_busy_read_zero;
		I_RD && I_ADDR > 8'h2f && O_MISSION_RUNNING |=> O_RDATA == 8'h00;
	endproperty
	a_busy_read_zero: assert property (p_busy_read_zero) else $error("mission read not zero");
	property p_unmapped_zero;
		I_RD && I_ADDR > 8'h43 |=> O_RDATA == 8'h00;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("reserved read not zero");
	property p_rdata_hold;
		!I_RD |=> $stable(O_RDATA);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
endmodule
bind event_log_mission_control evlog_mission_props evlog_mission_props_i (
	.I_REF_CLK(I_REF_CLK), .I_RESET_N(I_RESET_N), .I_CLEAR_DONE(I_CLEAR_DONE), .I_WR(I_WR),
	.I_RD(I_RD), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .O_RDATA(O_RDATA),
	.O_MISSION_RUNNING(O_MISSION_RUNNING), .O_MISSION_ARM(O_MISSION_ARM));

// ### dv/evlog_event_source.sv
// Behavioural model of the external event source with its own free-running clock.
`timescale 1ns/1ps
module evlog_event_source (
	input  wire logic i_level,
	output logic      o_event
);
	logic link_clk;
	logic held = 1'b0;
	assign o_event = held;
	// The pin moves only on the source clock, so edges always land at the same phase of the block clock.
	initial begin
		link_clk = 1'b0;
		#7;
		forever #160 link_clk = ~link_clk;
	end
	always @(posedge link_clk)
		held <= i_level;
endmodule

// ### dv/event_log_mission_control_bench.sv
// Self-checking bench for the event-log mission controller.
`timescale 1ns/1ps
module event_log_mission_control_bench;
	logic        I_REF_CLK = 1'b0;
	logic        I_RESET_N = 1'b0;
	logic        I_EVENT;
	logic [63:0] I_RTC_TIME = 64'h0123456789abcdef;
	logic        I_SEC_TICK = 1'b0;
	logic        I_MIN_TICK = 1'b0;
	logic        I_HOUR_TICK = 1'b0;
	logic        I_CLEAR_DONE = 1'b0;
	logic        I_WR = 1'b0;
	logic        I_RD = 1'b0;
	logic [7:0]  I_ADDR = 8'h00;
	logic [7:0]  I_WDATA = 8'h00;
	logic [7:0]  O_RDATA;
	logic        O_MISSION_RUNNING;
	logic        O_MISSION_ARM;
	logic        level = 1'b0;
	logic [25:0] r;
	int          err_count = 0;
	int          total_checks = 0;
	// Row: control byte, arm, running after rise, event count, first log byte.
	logic [25:0] rows [7] = '{{8'h96, 2'b11, 8'h02, 8'h01}, {8'ha6, 2'b11, 8'h02, 8'h02},
		{8'hb6, 2'b11, 8'h02, 8'h03}, {8'h94, 2'b11, 8'h01, 8'h00}, {8'h92, 2'b10, 8'h01, 8'h00},
		{8'h90, 2'b00, 8'h00, 8'h00}, {8'h86, 2'b00, 8'h00, 8'h00}};
	always #20 I_REF_CLK = ~I_REF_CLK;
	event_log_mission_control event_log_mission_control_i (.I_REF_CLK(I_REF_CLK), .I_RESET_N(I_RESET_N),
		.I_EVENT(I_EVENT), .I_RTC_TIME(I_RTC_TIME), .I_SEC_TICK(I_SEC_TICK), .I_MIN_TICK(I_MIN_TICK),
		.I_HOUR_TICK(I_HOUR_TICK), .I_CLEAR_DONE(I_CLEAR_DONE), .I_WR(I_WR), .I_RD(I_RD), .I_ADDR(I_ADDR),
		.I_WDATA(I_WDATA), .O_RDATA(O_RDATA), .O_MISSION_RUNNING(O_MISSION_RUNNING),
		.O_MISSION_ARM(O_MISSION_ARM));
	evlog_event_source evlog_event_source_i (.i_level(level), .o_event(I_EVENT));
	// ********
	// Bus, pin and compare tasks
	// ********
	task automatic finish_test();
		if (err_count == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("Error t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic st(input logic [1:0] e);
		#1 chk({6'h0, O_MISSION_ARM, O_MISSION_RUNNING}, {6'h0, e});
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge I_REF_CLK);
		I_WR    <= 1'b1;
		I_ADDR  <= a;
		I_WDATA <= v;
		@(posedge I_REF_CLK);
		I_WR <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge I_REF_CLK);
		I_RD   <= 1'b1;
		I_ADDR <= a;
		@(posedge I_REF_CLK);
		I_RD <= 1'b0;
		@(posedge I_REF_CLK);
		#1 chk(O_RDATA & m, e);
	endtask
	task automatic pulse(input int s, input int n);
		repeat (n) begin
			@(posedge I_REF_CLK);
			{I_HOUR_TICK, I_MIN_TICK, I_SEC_TICK} <= 3'h1 << s;
			@(posedge I_REF_CLK);
			{I_HOUR_TICK, I_MIN_TICK, I_SEC_TICK} <= 3'h0;
		end
	endtask
	// The wait covers the source clock, the synchroniser and the two log cycles.
	task automatic tog();
		@(posedge I_REF_CLK);
		level <= ~level;
		repeat (16) @(posedge I_REF_CLK);
	endtask
	task automatic clr();
		@(posedge I_REF_CLK);
		I_CLEAR_DONE <= 1'b1;
		@(posedge I_REF_CLK);
		I_CLEAR_DONE <= 1'b0;
	endtask
	task automatic stop(input logic [7:0] a);
		wr(a, 8'h00);
		repeat (4) @(posedge I_REF_CLK);
		st(2'b00);
	endtask
	task automatic full(input logic [7:0] ctl, input logic wrap);
		I_RTC_TIME <= 64'h0123456789abcdef;
		clr();
		wr(8'h0e, ctl);
		wr(8'h0f, 8'h20);
		repeat (1024) tog();
		I_RTC_TIME <= 64'h1122334455667788;
		pulse(0, 3);
		tog();
		pulse(0, 2);
		tog();
		stop(8'h10);
		rdc(8'h3a, 8'hff, 8'h03);
		rdc(8'h3b, 8'hff, 8'h04);
		rdc(8'h38, 8'hff, wrap ? 8'h03 : 8'h00);
		rdc(8'h30, 8'hff, wrap ? 8'h88 : 8'hef);
		rdc(8'h0f, 8'h04, wrap ? 8'h04 : 8'h00);
		rdc(8'h3f, 8'hff, wrap ? 8'h02 : 8'h00);
		wr(8'h41, 8'h00);
		wr(8'h42, 8'h00);
		rdc(8'h43, 8'hff, wrap ? 8'h02 : 8'h00);
	endtask
	initial begin
		repeat (60000) @(posedge I_REF_CLK);
		err_count++;
		finish_test();
	end
	// ********
	// Test sequence
	// ********
	initial begin
		repeat (3) @(posedge I_REF_CLK);
		I_RESET_N <= 1'b1;
		st(2'b00);
		rdc(8'h50, 8'hff, 8'h00);
		for (int i = 0; i < 7; i++) begin
			r = rows[i];
			clr();
			wr(8'h0e, r[25:18]);
			st({r[17], 1'b0});
			tog();
			st({r[17], r[16]});
			pulse(0, 1);
			pulse(1, 2);
			pulse(2, 3);
			tog();
			st({r[17], r[15:8] != 8'h00});
			stop(8'h0f);
			rdc(8'h3a, 8'hff, r[15:8]);
			if (r[15:8] == 8'h02) begin
				wr(8'h41, 8'h00);
				wr(8'h42, 8'h00);
				rdc(8'h43, 8'hff, r[7:0]);
			end
		end
		clr();
		wr(8'h0e, 8'h16);
		wr(8'h0f, 8'h20);
		st(2'b11);
		rdc(8'h3a, 8'hff, 8'h00);
		pulse(0, 3);
		tog();
		pulse(0, 5);
		pulse(1, 1);
		tog();
		stop(8'h0f);
		for (int i = 0; i < 8; i++)
			rdc(8'(8'h30 + i), 8'hff, I_RTC_TIME[8*i +: 8]);
		rdc(8'h38, 8'hff, 8'h00);
		rdc(8'h3a, 8'hff, 8'h03);
		rdc(8'h3f, 8'hff, 8'h04);
		wr(8'h41, 8'h02);
		wr(8'h42, 8'hf8);
		rdc(8'h43, 8'hff, 8'h05);
		rdc(8'h43, 8'hff, 8'h00);
		wr(8'h43, 8'haa);
		wr(8'h41, 8'h00);
		wr(8'h42, 8'h00);
		rdc(8'h43, 8'hff, 8'h03);
		wr(8'h0f, 8'h20);
		st(2'b00);
		full(8'h16, 1'b0);
		full(8'h1e, 1'b1);
		finish_test();
	end
endmodule
